// file: common/mailbox_pkg.sv
// Constants, enumerations and carrier structs of the RF/host buffer mailbox.
// Assumes one clock domain; RF framing and serial decoding happen outside.
package mailbox_pkg;
  localparam int BUF_BYTES = 32;
  localparam logic [7:0] BLK_FIRST = 8'hFC;
  localparam logic [7:0] BLK_SECOND = 8'hFD;
  localparam logic [7:0] BLK_THIRD = 8'hFE;
  localparam logic [7:0] BLK_LAST = 8'hFF;
  localparam logic [7:0] FLAGS_READY = 8'h01;
  localparam logic [7:0] FLAGS_BUSY = 8'h02;
  localparam logic [2:0] NAK_MAX = 3'h5;
  localparam int TUN_EN_BIT = 6;
  localparam int EXT_EN_BIT = 5;
  localparam int CRC_EN_BIT = 7;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h80;

  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'b00,
    MODE_TUNNEL = 2'b01,
    MODE_EXTENDED = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    EXT_IDLE = 2'b00,
    EXT_RX = 2'b01,
    EXT_READY = 2'b10,
    EXT_TX = 2'b11
  } ext_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_CLEAR = 3'b001,
    CMD_TRANSMIT = 3'b010,
    CMD_ACK = 3'b011,
    CMD_NAK = 3'b100,
    CMD_SLEEP = 3'b101,
    CMD_SENSE = 3'b110,
    CMD_SENSE_SLEEP = 3'b111
  } host_cmd_t;

  typedef enum logic [2:0] {
    RESP_NONE = 3'b000,
    RESP_ACK = 3'b001,
    RESP_NAK = 3'b010,
    RESP_ERR = 3'b011,
    RESP_DATA = 3'b100,
    RESP_BUF = 3'b101
  } resp_kind_t;

  typedef enum logic [1:0] {
    TAG_NONE = 2'b00,
    TAG_SLEEP = 2'b01,
    TAG_SENSE = 2'b10,
    TAG_SENSE_SLEEP = 2'b11
  } tag_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] data;
    logic err;
  } rf_cmd_t;

  typedef struct packed {
    logic start;
    logic bvalid;
    logic [7:0] data;
    logic is_crc;
    logic stop;
    logic crc_err;
    logic par_err;
    logic frm_err;
  } rf_rx_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] data;
    host_cmd_t cmd;
    logic [2:0] nak;
  } host_t;

  typedef struct packed {
    resp_kind_t kind;
    logic [2:0] nak;
    logic [5:0] len;
    logic [127:0] data;
  } rf_resp_t;

  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic tx_end;
    logic crc_err;
    logic par_err;
    logic frm_err;
    logic buf_err;
    logic acc_err;
  } irq_t;
endpackage

// file: core/buffer_store.sv
// Byte-addressed shared message buffer held in flip-flops.
// Assumes at most one writer per cycle; the arbiter above guarantees it.
`timescale 1ns/1ns
`default_nettype none
module buffer_store
  import mailbox_pkg::*;
#(
  parameter int DEPTH = BUF_BYTES,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic byte_wr,
  input wire logic [AW-1:0] byte_idx,
  input wire logic [7:0] byte_data,
  input wire logic word_wr,
  input wire logic [1:0] word_idx,
  input wire logic [31:0] word_data,
  output logic [DEPTH*8-1:0] image
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } store_t;

  store_t state_reg;
  store_t state_next;
  logic [DEPTH-1:0][7:0] mem_next;

  // Word writes cover only the low sixteen bytes, four per reader block.
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    localparam logic [AW-1:0] IDX = AW'(i);
    assign mem_next[i] = clear ? 8'h00 :
      (word_wr && IDX[AW-1:2] == (AW-2)'(word_idx)) ? word_data[IDX[1:0]*8 +: 8] :
      (byte_wr && byte_idx == IDX) ? byte_data : state_reg.mem[i];
  end

  always_comb begin
    state_next = state_reg;
    state_next.mem = mem_next;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign image = state_reg.mem;
endmodule
`default_nettype wire

// file: core/mode_select.sv
// Configuration bytes and the resulting communication mode.
// Assumes the host serial decoder presents single-cycle write strobes.
`timescale 1ns/1ns
`default_nettype none
module mode_select
  import mailbox_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cfg1_wr,
  input wire logic cfg2_wr,
  input wire logic [7:0] cfg_data,
  output mode_t mode,
  output logic crc_store
);
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] second_config_byte;
    mode_t mode;
  } cfg_state_t;

  cfg_state_t state_reg;
  cfg_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (cfg1_wr) begin
      state_next.cfg1 = cfg_data;
    end
    if (cfg2_wr) begin
      state_next.second_config_byte = cfg_data;
    end
    if (state_next.second_config_byte[TUN_EN_BIT]) begin
      state_next.mode = MODE_TUNNEL;
    end else if (state_next.second_config_byte[EXT_EN_BIT]) begin
      state_next.mode = MODE_EXTENDED;
    end else begin
      state_next.mode = MODE_STANDALONE;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= '{cfg1: CFG1_RESET, second_config_byte: CFG2_RESET, mode: MODE_STANDALONE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mode = state_reg.mode;
  assign crc_store = state_reg.cfg1[CRC_EN_BIT];
endmodule
`default_nettype wire

// file: core/rf_host_buffer_mailbox.sv
// Mailbox between the RF frontend and the host serial interface.
// Assumes the frontend delivers decoded reader commands and raw tunnel bytes,
// and that the serial decoder turns host traffic into one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Tunneling blocks reader memory access; all selected-state frames go to buffer.
// - Tunneled reception raises error, buffer, access, start, end interrupts.
// - Host decides replies; ack or nak code 0 to 5 on command.
// - Host loads buffer, transmit command sends it over RF.
// - Host keeps memory access during RF traffic in tunneling mode.
// - Blocks FCh to FFh map in order onto buffer bytes 0 to 15.
// - Extended write data with any reception error never reaches buffer.
// - Extended block writes that store data or release the buffer get an automatic acknowledge; a same-cycle host nak wins.
// - Reader sends 16 bytes; host sends 12 data, 3 empty, 1 flags.
// - Buffer owned by one side at a time, RF or host.
// - Buffer kept while powered; cleared when field returns after loss.
// - First FCh write sets busy, rx-start, locks host until FFh rx-end.
// - FFh write before any FCh write is an error.
// - FFh sets ready flag; further writes refused until host clears.
// - Host reads from byte 0 in order; clear command frees buffer.
// - Host clears, writes three words, transmits; device sets host-ready.
// - Reader read of FCh returns three host words plus a flags word.
// - Reader FFh write after reading clears buffer and raises tx-end.
// - Early FCh read gives zero data, busy flags; ready reads 01h.
// - Extended reads accepted only at FCh; others are errors.
// - Host byte write before reader FFh release is refused with access error.
// - Tunneling wins over extended; neither means standalone tag behaviour.
// - Tunnel enable bit 6, extended bit 5, host may change both.
// - Buffer of 32 bytes with a write pointer; host reads use a separate index.
// - Optional stored CRC bytes in tunnel buffer; checking always done.
module rf_host_buffer_mailbox
  import mailbox_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic field_on,
  input wire logic selected,
  input wire rf_cmd_t rf_cmd,
  input wire rf_rx_t rf_rx,
  input wire logic rf_tx_done,
  input wire host_t host,
  input wire logic cfg1_wr,
  input wire logic cfg2_wr,
  input wire logic [7:0] cfg_data,
  output rf_resp_t rf_resp,
  output irq_t irq,
  output logic radio_side_busy_flag,
  output logic radio_message_ready_flag,
  output logic host_data_ready,
  output logic [5:0] buf_count,
  output logic [7:0] host_rd_data,
  output logic host_rd_valid,
  output tag_cmd_t tag_cmd,
  output logic rf_eeprom_en,
  output logic host_eeprom_en,
  output mode_t op_mode,
  output logic [BUF_BYTES*8-1:0] buf_image
);
  typedef struct packed {
    ext_state_t ext;
    logic tun_busy;
    logic fld_q;
    logic [5:0] ptr;
    logic [4:0] rd_idx;
    rf_resp_t resp;
    irq_t irq;
    tag_cmd_t tag_cmd;
    logic [7:0] rd_data;
    logic rd_valid;
    logic busy;
    logic ready;
    logic host_ready;
    logic eeprom_rf;
    logic eeprom_host;
  } state_t;

  state_t s;
  state_t n;
  logic crc_store;
  logic buf_clear;
  logic buf_wr;
  logic [4:0] buf_idx;
  logic [7:0] buf_byte;
  logic word_wr;
  logic rf_took;
  logic host_locked;
  logic ext_on;
  logic tun_on;

  mode_select u_mode (
    .clock(clock),
    .reset(reset),
    .cfg1_wr(cfg1_wr),
    .cfg2_wr(cfg2_wr),
    .cfg_data(cfg_data),
    .mode(op_mode),
    .crc_store(crc_store)
  );

  buffer_store #(.DEPTH(BUF_BYTES)) u_buf (
    .clock(clock),
    .reset(reset),
    .clear(buf_clear),
    .byte_wr(buf_wr),
    .byte_idx(buf_idx),
    .byte_data(buf_byte),
    .word_wr(word_wr),
    .word_idx(rf_cmd.addr[1:0]),
    .word_data(rf_cmd.data),
    .image(buf_image)
  );

  assign ext_on = selected && op_mode == MODE_EXTENDED;
  assign tun_on = selected && op_mode == MODE_TUNNEL;
  assign host_locked = s.ext == EXT_RX || s.tun_busy;

  always_comb begin
    n = s;
    n.irq = '0;
    n.resp = '0;
    n.tag_cmd = TAG_NONE;
    n.rd_valid = 1'b0;
    n.fld_q = field_on;
    buf_clear = 1'b0;
    buf_wr = 1'b0;
    buf_idx = s.ptr[4:0];
    buf_byte = host.data;
    word_wr = 1'b0;
    rf_took = 1'b0;
    n.eeprom_rf = op_mode != MODE_TUNNEL;
    n.eeprom_host = 1'b1;
    if (field_on && !s.fld_q) begin
      buf_clear = 1'b1;
      n.ptr = '0;
      n.rd_idx = '0;
      n.ext = EXT_IDLE;
      n.tun_busy = 1'b0;
    end else begin
      // ****************************************************************
      // Extended mode reader side
      // ****************************************************************
      if (ext_on && rf_cmd.valid && rf_cmd.write && rf_cmd.addr >= BLK_FIRST) begin
        n.resp.kind = RESP_ERR;
        if (!rf_cmd.err) begin
          case (rf_cmd.addr)
            BLK_FIRST: begin
              if (s.ext == EXT_IDLE || s.ext == EXT_RX) begin
                word_wr = 1'b1;
                n.irq.rx_start = s.ext == EXT_IDLE;
                n.ext = EXT_RX;
              end
            end
            BLK_SECOND, BLK_THIRD: begin
              word_wr = s.ext == EXT_RX;
            end
            default: begin
              // early last refused, ready flag set
              if (s.ext == EXT_RX) begin
                word_wr = 1'b1;
                n.irq.rx_end = 1'b1;
                n.ext = EXT_READY;
                n.ptr = 6'(BUF_BYTES / 2);
              end else if (s.ext == EXT_TX) begin
                buf_clear = 1'b1;
                rf_took = 1'b1;
                n.ptr = '0;
                n.irq.tx_end = 1'b1;
                n.ext = EXT_IDLE;
              end
            end
          endcase
          if (word_wr) begin
            rf_took = 1'b1;
          end
          if (word_wr || buf_clear) begin
            n.resp.kind = RESP_ACK;
          end
        end
      end else if (ext_on && rf_cmd.valid && !rf_cmd.write) begin
        if (rf_cmd.err || rf_cmd.addr != BLK_FIRST) begin
          n.resp.kind = RESP_ERR;
        end else begin
          n.resp.kind = RESP_DATA;
          if (s.ext == EXT_TX) begin
            n.resp.data = {FLAGS_READY, 24'h000000, buf_image[95:0]};
          end else begin
            n.resp.data = {FLAGS_BUSY, 120'h0};
          end
        end
      end
      // ****************************************************************
      // Tunneling mode reader side
      // ****************************************************************
      if (tun_on && rf_rx.start) begin
        n.tun_busy = 1'b1;
        n.ptr = '0;
        n.rd_idx = '0;
        n.irq.rx_start = 1'b1;
        rf_took = 1'b1;
      end else if (tun_on && s.tun_busy && rf_rx.bvalid) begin
        rf_took = 1'b1;
        if (!rf_rx.is_crc || crc_store) begin
          if (s.ptr == 6'(BUF_BYTES)) begin
            n.irq.buf_err = 1'b1;
          end else begin
            buf_wr = 1'b1;
            buf_byte = rf_rx.data;
            n.ptr = s.ptr + 6'h01;
          end
        end
      end
      if (tun_on && s.tun_busy && rf_rx.stop) begin
        n.tun_busy = 1'b0;
        n.irq.rx_end = 1'b1;
        n.irq.crc_err = rf_rx.crc_err;
        n.irq.par_err = rf_rx.par_err;
        n.irq.frm_err = rf_rx.frm_err;
      end
      if (tun_on && rf_tx_done) begin
        n.irq.tx_end = 1'b1;
      end
      // ****************************************************************
      // Host side
      // ****************************************************************
      if (host.wr) begin
        if (host_locked || rf_took || s.ext == EXT_TX) begin
          n.irq.acc_err = 1'b1;
        end else if (s.ptr == 6'(BUF_BYTES)) begin
          n.irq.buf_err = 1'b1;
        end else begin
          buf_wr = 1'b1;
          n.ptr = s.ptr + 6'h01;
        end
      end
      if (host.rd) begin
        if (host_locked || rf_took) begin
          n.irq.acc_err = 1'b1;
        end else begin
          n.rd_data = buf_image[s.rd_idx*8 +: 8];
          n.rd_valid = 1'b1;
          n.rd_idx = s.rd_idx + 5'h01;
        end
      end
      case (host.cmd)
        CMD_CLEAR: begin
          if (host_locked || rf_took) begin
            n.irq.acc_err = 1'b1;
          end else begin
            buf_clear = 1'b1;
            n.ptr = '0;
            n.rd_idx = '0;
            n.ext = EXT_IDLE;
          end
        end
        CMD_TRANSMIT: begin
          if (host_locked || rf_took) begin
            n.irq.acc_err = 1'b1;
          end else if (ext_on) begin
            n.ext = EXT_TX;
          end else if (tun_on) begin
            n.resp.kind = RESP_BUF;
            n.resp.len = s.ptr;
          end
        end
        CMD_ACK: begin
          n.resp.kind = RESP_ACK;
        end
        CMD_NAK: begin
          if (host.nak <= NAK_MAX) begin
            n.resp.kind = RESP_NAK;
            n.resp.nak = host.nak;
          end
        end
        CMD_SLEEP: n.tag_cmd = TAG_SLEEP;
        CMD_SENSE: n.tag_cmd = TAG_SENSE;
        CMD_SENSE_SLEEP: n.tag_cmd = TAG_SENSE_SLEEP;
        default: n.tag_cmd = TAG_NONE;
      endcase
    end
    n.busy = n.ext == EXT_RX || n.tun_busy;
    n.ready = n.ext == EXT_READY;
    n.host_ready = n.ext == EXT_TX;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rf_resp = s.resp;
  assign irq = s.irq;
  assign radio_side_busy_flag = s.busy;
  assign radio_message_ready_flag = s.ready;
  assign host_data_ready = s.host_ready;
  assign buf_count = s.ptr;
  assign host_rd_data = s.rd_data;
  assign host_rd_valid = s.rd_valid;
  assign tag_cmd = s.tag_cmd;
  assign rf_eeprom_en = s.eeprom_rf;
  assign host_eeprom_en = s.eeprom_host;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic ext_wr_ok;
  assign ext_wr_ok = ext_on && rf_cmd.valid && rf_cmd.write && !rf_cmd.err
    && !(field_on && !s.fld_q);

  host_lockout_a: assert property (
    (s.ext == EXT_RX && host.wr && !rf_cmd.valid && !rf_rx.bvalid && !(field_on && !s.fld_q))
      |=> irq.acc_err && $stable(buf_image))
    else $error("host write landed while radio owns buffer");
  bad_write_drop_a: assert property (
    (ext_on && rf_cmd.valid && rf_cmd.write && rf_cmd.err && rf_cmd.addr >= BLK_FIRST
      && !host.wr && !rf_rx.bvalid && host.cmd == CMD_NONE && !(field_on && !s.fld_q))
      |=> rf_resp.kind == RESP_ERR && $stable(buf_image)) else $error("errored write kept");
  early_last_a: assert property (
    (ext_wr_ok && rf_cmd.addr == BLK_LAST && s.ext == EXT_IDLE && host.cmd == CMD_NONE)
      |=> rf_resp.kind == RESP_ERR) else $error("FFh before FCh not refused");
  ready_reject_a: assert property (
    (ext_wr_ok && s.ext == EXT_READY && rf_cmd.addr >= BLK_FIRST && host.cmd == CMD_NONE)
      |=> rf_resp.kind == RESP_ERR && radio_message_ready_flag) else $error("write while ready");
  message_end_a: assert property (
    (ext_wr_ok && rf_cmd.addr == BLK_LAST && s.ext == EXT_RX && host.cmd == CMD_NONE)
      |=> irq.rx_end && radio_message_ready_flag && !radio_side_busy_flag
      && rf_resp.kind == RESP_ACK) else $error("message end not flagged");
  poll_flags_a: assert property (
    (ext_on && rf_cmd.valid && !rf_cmd.write && !rf_cmd.err && rf_cmd.addr == BLK_FIRST
      && s.ext != EXT_TX && host.cmd == CMD_NONE && !(field_on && !s.fld_q))
      |=> rf_resp.data == {FLAGS_BUSY, 120'h0}) else $error("early poll data wrong");
  read_addr_a: assert property (
    (ext_on && rf_cmd.valid && !rf_cmd.write && rf_cmd.addr != BLK_FIRST
      && host.cmd == CMD_NONE && !(field_on && !s.fld_q))
      |=> rf_resp.kind == RESP_ERR) else $error("read of other block accepted");
  tunnel_block_a: assert property (
    op_mode == MODE_TUNNEL |=> !rf_eeprom_en) else $error("reader memory open in tunnel");
  nak_code_a: assert property (
    rf_resp.kind == RESP_NAK |-> rf_resp.nak <= NAK_MAX) else $error("nak code out of range");

  start_msg_c: cover property (ext_wr_ok && rf_cmd.addr == BLK_FIRST ##[1:20] irq.rx_end);
  host_tx_c: cover property (host_data_ready ##[1:20] irq.tx_end);
  tunnel_rx_c: cover property (irq.rx_start && s.tun_busy ##[1:40] irq.rx_end);
endmodule
`default_nettype wire

// file: sim/reader_model.sv
// Reader on the RF side: issues decoded block commands one at a time.
// Assumes the mailbox answers at the same edge that takes a command.
`timescale 1ns/1ns
`default_nettype none
module reader_model
  import mailbox_pkg::*;
(
  input wire logic clock,
  input wire rf_resp_t rf_resp,
  output var rf_cmd_t rf_cmd
);
  initial begin
    rf_cmd = '0;
  end

  // whole words, release and polling reads
  // Released address and data are inverted so that stale values never look valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic e, output rf_resp_t r);
    @(posedge clock);
    #1;
    rf_cmd = '{valid: 1'b1, write: w, addr: a, data: d, err: e};
    @(posedge clock);
    #1;
    r = rf_resp;
    rf_cmd = '{valid: 1'b0, write: ~w, addr: ~a, data: ~d, err: ~e};
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the mailbox with a reader model on the RF side.
// Assumes the host side is driven here as one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mailbox_pkg::*;
  logic clock, reset, field_on, selected, cfg2_wr, busy, ready, hdr, hrv, rf_ee, host_ee;
  logic rf_tx_done, cfg1_wr;
  rf_rx_t rf_rx;
  logic [7:0] cfg_data, hrd;
  logic [5:0] buf_count;
  logic [BUF_BYTES*8-1:0] buf_image;
  host_t host;
  rf_cmd_t rf_cmd;
  rf_resp_t rf_resp, r;
  irq_t irq;
  tag_cmd_t tag_cmd;
  mode_t op_mode;
  int errors, checks_done;

  rf_host_buffer_mailbox dut (.clock(clock), .reset(reset), .field_on(field_on),
    .selected(selected), .rf_cmd(rf_cmd), .rf_rx(rf_rx), .rf_tx_done(rf_tx_done), .host(host),
    .cfg1_wr(cfg1_wr), .cfg2_wr(cfg2_wr), .cfg_data(cfg_data), .rf_resp(rf_resp), .irq(irq),
    .radio_side_busy_flag(busy), .radio_message_ready_flag(ready), .host_data_ready(hdr),
    .buf_count(buf_count), .host_rd_data(hrd), .host_rd_valid(hrv), .tag_cmd(tag_cmd),
    .rf_eeprom_en(rf_ee), .host_eeprom_en(host_ee), .op_mode(op_mode),
    .buf_image(buf_image));
  reader_model reader (.clock(clock), .rf_resp(rf_resp), .rf_cmd(rf_cmd));

  // ****************************************
  // Common tasks
  // ****************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cfg2(input logic [7:0] v);
    @(posedge clock);
    #1;
    cfg2_wr = 1'b1;
    cfg_data = v;
    @(posedge clock);
    #1;
    cfg2_wr = 1'b0;
  endtask

  // The answer of the edge that takes the strobe is settled when this returns.
  task automatic hop(input host_cmd_t c, input logic w, input logic rd, input logic [7:0] d,
                     input logic [2:0] n);
    @(posedge clock);
    #1;
    host = '{wr: w, rd: rd, data: d, cmd: c, nak: n};
    @(posedge clock);
    #1;
    host = '{wr: 1'b0, rd: 1'b0, data: ~d, cmd: CMD_NONE, nak: 3'h0};
  endtask

  // One cycle of the tunnel byte stream; e holds crc, parity and framing errors.
  task automatic rx_pulse(input logic st, input logic bv, input logic [7:0] d, input logic c,
                          input logic sp, input logic [2:0] e);
    @(posedge clock);
    #1;
    rf_rx = '{start: st, bvalid: bv, data: d, is_crc: c, stop: sp, crc_err: e[2],
              par_err: e[1], frm_err: e[0]};
    @(posedge clock);
    #1;
    rf_rx = '0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_mode();
    cfg2(8'h60);
    check(op_mode, MODE_TUNNEL, "both enables");
    @(posedge clock);
    #1;
    check(rf_ee, 1'b0, "reader memory path");
    check(host_ee, 1'b1, "host memory path");
    hop(CMD_ACK, 1'b0, 1'b0, 8'h00, 3'h0);
    check(rf_resp.kind, RESP_ACK, "ack cmd");
    for (int n = 0; n <= 5; n++) begin
      hop(CMD_NAK, 1'b0, 1'b0, 8'h00, 3'(n));
      check({rf_resp.kind, rf_resp.nak}, {RESP_NAK, 3'(n)}, "nak cmd");
    end
    hop(CMD_NAK, 1'b0, 1'b0, 8'h00, 3'h6);
    check(rf_resp.kind, RESP_NONE, "nak code refused");
    hop(CMD_SENSE_SLEEP, 1'b0, 1'b0, 8'h00, 3'h0);
    check(tag_cmd, TAG_SENSE_SLEEP, "state cmd");
    cfg2(8'h00);
    check(op_mode, MODE_STANDALONE, "no enable");
    cfg2(8'h20);
    check(op_mode, MODE_EXTENDED, "extended enable");
    $display("test mode done");
  endtask

  task automatic t_rx();
    reader.xfer(1'b1, BLK_LAST, 32'h0, 1'b0, r);
    check(r.kind, RESP_ERR, "last before first");
    reader.xfer(1'b1, BLK_FIRST, 32'h5A5A5A5A, 1'b1, r);
    check(r.kind, RESP_ERR, "errored write");
    check(buf_image[31:0], 32'h0, "errored data kept out");
    for (int i = 0; i < 4; i++) begin
      reader.xfer(1'b1, BLK_FIRST + 8'(i),
                  {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)}, 1'b0, r);
      check(r.kind, RESP_ACK, "block write ack");
      if (i == 0) begin
        check({irq.rx_start, busy}, 2'b11, "receive start");
        hop(CMD_NONE, 1'b1, 1'b0, 8'h77, 3'h0);
        check(irq.acc_err, 1'b1, "host write while busy");
      end
    end
    check({irq.rx_end, busy, ready}, 3'b101, "receive end");
    check(buf_count, 6'd16, "pointer");
    @(posedge clock);
    #1;
    check(buf_image[127:0], 128'h0F0E0D0C0B0A09080706050403020100, "block map");
    reader.xfer(1'b1, BLK_FIRST, 32'h0, 1'b0, r);
    check(r.kind, RESP_ERR, "write while ready");
    for (int k = 0; k < 16; k++) begin
      hop(CMD_NONE, 1'b0, 1'b1, 8'h00, 3'h0);
      check({hrv, hrd}, {1'b1, 8'(k)}, "host read order");
    end
    hop(CMD_CLEAR, 1'b0, 1'b0, 8'h00, 3'h0);
    check(ready, 1'b0, "clear frees");
    $display("test rx done");
  endtask

  task automatic t_tx();
    logic [95:0] words;
    reader.xfer(1'b0, BLK_FIRST, 32'h0, 1'b0, r);
    check(r.data, {FLAGS_BUSY, 120'h0}, "early read");
    hop(CMD_CLEAR, 1'b0, 1'b0, 8'h00, 3'h0);
    for (int k = 0; k < 12; k++) begin
      hop(CMD_NONE, 1'b1, 1'b0, 8'hA0 + 8'(k), 3'h0);
      words[8*k +: 8] = 8'hA0 + 8'(k);
    end
    hop(CMD_TRANSMIT, 1'b0, 1'b0, 8'h00, 3'h0);
    check(hdr, 1'b1, "host data ready");
    reader.xfer(1'b0, BLK_FIRST, 32'h0, 1'b0, r);
    check(r.kind, RESP_DATA, "read kind");
    check(r.data, {FLAGS_READY, 24'h0, words}, "read words");
    reader.xfer(1'b0, BLK_SECOND, 32'h0, 1'b0, r);
    check(r.kind, RESP_ERR, "read off first block");
    reader.xfer(1'b1, BLK_LAST, 32'h0, 1'b0, r);
    check({r.kind, irq.tx_end, hdr}, {RESP_ACK, 2'b10}, "release");
    $display("test tx done");
  endtask

  task automatic t_field();
    reader.xfer(1'b1, BLK_FIRST, 32'hC3C3C3C3, 1'b0, r);
    @(posedge clock);
    #1;
    field_on = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(buf_image[31:0], 32'hC3C3C3C3, "kept without field");
    field_on = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({buf_image[31:0], buf_count}, 38'h0, "field return clears");
    $display("test field done");
  endtask

  task automatic t_tunnel();
    cfg2(8'h40);
    rx_pulse(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    check({irq.rx_start, busy}, 2'b11, "tunnel start");
    rx_pulse(1'b0, 1'b1, 8'h11, 1'b0, 1'b0, 3'h0);
    rx_pulse(1'b0, 1'b1, 8'h22, 1'b0, 1'b0, 3'h0);
    rx_pulse(1'b0, 1'b1, 8'h33, 1'b1, 1'b0, 3'h0);
    rx_pulse(1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 3'h5);
    check({irq.rx_end, irq.crc_err, irq.par_err, irq.frm_err, busy}, 5'b11010,
          "tunnel end");
    check({buf_count, buf_image[15:0]}, {6'd2, 16'h2211}, "frame stored");
    hop(CMD_TRANSMIT, 1'b0, 1'b0, 8'h00, 3'h0);
    check({rf_resp.kind, rf_resp.len}, {RESP_BUF, 6'd2}, "buffer reply");
    @(posedge clock);
    #1;
    rf_tx_done = 1'b1;
    @(posedge clock);
    #1;
    rf_tx_done = 1'b0;
    check(irq.tx_end, 1'b1, "tunnel tx end");
    for (int k = 2; k < 32; k++) begin
      hop(CMD_NONE, 1'b1, 1'b0, 8'(k), 3'h0);
    end
    hop(CMD_NONE, 1'b1, 1'b0, 8'hEE, 3'h0);
    check({irq.buf_err, buf_count}, {1'b1, 6'd32}, "full buffer");
    @(posedge clock);
    #1;
    cfg1_wr = 1'b1;
    cfg_data = 8'h80;
    @(posedge clock);
    #1;
    cfg1_wr = 1'b0;
    rx_pulse(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    rx_pulse(1'b0, 1'b1, 8'h44, 1'b0, 1'b0, 3'h0);
    rx_pulse(1'b0, 1'b1, 8'h55, 1'b1, 1'b0, 3'h0);
    check({buf_count, buf_image[15:0]}, {6'd2, 16'h5544}, "crc bytes stored");
    $display("test tunnel done");
  endtask

  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    field_on = 1'b1;
    selected = 1'b1;
    cfg2_wr = 1'b0;
    cfg1_wr = 1'b0;
    rf_tx_done = 1'b0;
    rf_rx = '0;
    cfg_data = 8'h00;
    host = '0;
    repeat (12) @(posedge clock);
    #1;
    reset = 1'b0;
    t_mode();
    t_rx();
    t_tx();
    t_field();
    t_tunnel();
    close_out();
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    #40000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
